// ==== verilog/agp_map.vh ====
// Contract
// - Port 1 has an 8-bit write-only direction register, one bit per pin.
// - Reset or hardware standby clears port 1 direction; software standby keeps.
// - In software standby, pins set as outputs keep driving their prior state.
// - Port 1 has an 8-bit read/write output latch, one bit per pin.
// - Reading a pin set as output returns its latch bit, not the pin.
// - Reading a pin set as input returns the sampled pin level.
// - Reset or hardware standby clears port 1 latch; software standby keeps it.
// - Modes 1 and 3: every port 1 pin is an address output.
// - Mode 5: direction one drives address bit, zero makes a general input.
// - Mode 5 starts with all pins input; software sets direction for address.
// - Modes 6 and 7: direction one is general output, zero general input.
// - Modes 1 and 3: every port 2 pin outputs the address upper byte.
// - Mode 5: port 2 direction bits pick address output or input per pin.
// - Single-chip modes: port 2 is eight general I/O pins, per-pin direction.
// - Port 2 has software-switchable pull-ups on its pins.
// - Port 2 has an 8-bit write-only direction register, one bit per pin.
// - Pull-up on only if control one and direction zero, never in 1 or 3.
// - Reset or hardware standby clears pull-up control; software standby keeps.
// - Port 2 read returns latch for output pins, pin level for inputs.
`ifndef AGP_MAP_VH
`define AGP_MAP_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define AGP_ADDR_W      18
`define AGP_P1_DIR_IDX  16'hffc0
`define AGP_P2_DIR_IDX  16'hffc1
`define AGP_P1_LAT_IDX  16'hffc2
`define AGP_P2_LAT_IDX  16'hffc3
`define AGP_P2_PUP_IDX  16'hffd8

// ----------------------------------------------------------------------
// Reset and fixed values
// ----------------------------------------------------------------------
`define AGP_DIR_RST     8'h00
`define AGP_LAT_RST     8'h00
`define AGP_PUP_RST     8'h00
`define AGP_DIR_FORCED  8'hff
`define AGP_WO_READ     8'hff

// ----------------------------------------------------------------------
// Operating modes
// ----------------------------------------------------------------------
`define AGP_MODE_EXP1   3'h1
`define AGP_MODE_EXP3   3'h3
`define AGP_MODE_EXPROM 3'h5
`define AGP_MODE_RST    3'h7

// ----------------------------------------------------------------------
// Register select codes
// ----------------------------------------------------------------------
`define AGP_SEL_NONE    3'h0
`define AGP_SEL_P1_DIR  3'h1
`define AGP_SEL_P1_LAT  3'h2
`define AGP_SEL_P2_DIR  3'h3
`define AGP_SEL_P2_LAT  3'h4
`define AGP_SEL_P2_PUP  3'h5

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define AGP_MODE_SETTLE 2'h3

`endif

// ==== verilog/agp_sync.v ====
`timescale 1ns/1ps
module agp_sync #(
  parameter W = 8
) (
  // Clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // Data
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

// ----------------------------------------------------------------------
// Two-stage synchroniser
// ----------------------------------------------------------------------
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // First stage feeds only the second
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // agp_sync

// ==== verilog/agp_top.v ====
`timescale 1ns/1ps
`include "agp_map.vh"
module agp_top (
  // Clock and reset
  input  wire                   pclk,
  input  wire                   presetn,
  // APB slave
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [`AGP_ADDR_W-1:0] paddr,
  input  wire [31:0]            pwdata,
  input  wire [3:0]             pstrb,
  output wire [31:0]            prdata,
  output wire                   pready,
  output wire                   pslverr,
  // Chip mode and power state
  input  wire [2:0]             mode_pins,
  input  wire                   hw_standby_n,
  input  wire                   sw_standby,
  // Expanded-mode address bus, low half
  input  wire [15:0]            ext_addr,
  // Port 1 pins
  input  wire [7:0]             p1_pin_in,
  output wire [7:0]             p1_pin_out,
  output wire [7:0]             p1_pin_oe,
  // Port 2 pins
  input  wire [7:0]             p2_pin_in,
  output wire [7:0]             p2_pin_out,
  output wire [7:0]             p2_pin_oe,
  output wire [7:0]             p2_pullup_on
);

// ----------------------------------------------------------------------
// Functions
// ----------------------------------------------------------------------
  function [2:0] agp_decode;
    input [`AGP_ADDR_W-1:0] a;
    begin
      if (a[1:0] != 2'h0)
        agp_decode = `AGP_SEL_NONE;
      else if (a[17:2] == `AGP_P1_DIR_IDX)
        agp_decode = `AGP_SEL_P1_DIR;
      else if (a[17:2] == `AGP_P1_LAT_IDX)
        agp_decode = `AGP_SEL_P1_LAT;
      else if (a[17:2] == `AGP_P2_DIR_IDX)
        agp_decode = `AGP_SEL_P2_DIR;
      else if (a[17:2] == `AGP_P2_LAT_IDX)
        agp_decode = `AGP_SEL_P2_LAT;
      else if (a[17:2] == `AGP_P2_PUP_IDX)
        agp_decode = `AGP_SEL_P2_PUP;
      else
        agp_decode = `AGP_SEL_NONE;
    end
  endfunction

  // Output pins read the latch, input pins the pin
  function [7:0] agp_readback;
    input [7:0] dir;
    input [7:0] lat;
    input [7:0] pin;
    begin
      agp_readback = (dir & lat) | (~dir & pin);
    end
  endfunction

  // Modes 1 and 3 pin every direction bit high
  function [7:0] agp_eff_dir;
    input       forced;
    input [7:0] dir;
    begin
      if (forced)
        agp_eff_dir = `AGP_DIR_FORCED;
      else
        agp_eff_dir = dir;
    end
  endfunction

// ----------------------------------------------------------------------
// Declarations
// ----------------------------------------------------------------------
  reg  [7:0]  p1_dir_q;
  reg  [7:0]  p2_dir_q;
  reg  [7:0]  p1_lat_q;
  reg  [7:0]  p2_lat_q;
  reg  [7:0]  p2_pup_q;
  reg  [2:0]  mode_q;
  reg  [1:0]  settle_q;
  reg         mode_lock_q;
  reg  [31:0] prdata_q;
  reg  [31:0] prdata_d;
  reg         pslverr_q;
  reg  [15:0] pin_out_q;
  reg  [15:0] pin_oe_q;
  reg  [7:0]  pup_q;
  reg  [7:0]  pup_d;

  wire [15:0] pin_s;
  wire [3:0]  ctl_s;
  wire        hw_stby;
  wire [2:0]  mode_s;
  wire        exp_norom;
  wire        single_chip;
  wire [7:0]  p1_dir_eff;
  wire [7:0]  p2_dir_eff;
  wire [15:0] dir_all;
  wire [15:0] lat_all;
  wire [15:0] drv_val;
  wire        setup_ph;
  wire        access_ph;
  wire [2:0]  sel;
  wire        wr_en;
  wire        dir_wr_ok;
  wire        p1_dir_we;
  wire        p2_dir_we;
  wire        p1_lat_we;
  wire        p2_lat_we;
  wire        p2_pup_we;

// ----------------------------------------------------------------------
// Input synchronisers
// ----------------------------------------------------------------------
  agp_sync #(
    .W (16)
  ) u_pin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({p2_pin_in, p1_pin_in}),
    .sync_out (pin_s)
  );

  agp_sync #(
    .W (4)
  ) u_ctl_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({hw_standby_n, mode_pins}),
    .sync_out (ctl_s)
  );

  // Synced low level also reads as standby, so pins stay off
  assign hw_stby = ~ctl_s[3];
  assign mode_s  = ctl_s[2:0];

// ----------------------------------------------------------------------
// Mode strap capture
// ----------------------------------------------------------------------
  // Mode pins are straps; catch them once after the sync settles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_q    <= 2'h0;
      mode_lock_q <= 1'b0;
      mode_q      <= `AGP_MODE_RST;
    end else if (!mode_lock_q) begin
      if (settle_q == `AGP_MODE_SETTLE) begin
        mode_lock_q <= 1'b1;
        mode_q      <= mode_s;
      end else begin
        settle_q <= settle_q + 2'h1;
      end
    end
  end

  assign exp_norom   = (mode_q == `AGP_MODE_EXP1) ||
                       (mode_q == `AGP_MODE_EXP3);
  assign single_chip = !exp_norom && (mode_q != `AGP_MODE_EXPROM);

// ----------------------------------------------------------------------
// Effective direction
// ----------------------------------------------------------------------
  // address outputs
  assign p1_dir_eff = agp_eff_dir(exp_norom, p1_dir_q);
  assign p2_dir_eff = agp_eff_dir(exp_norom, p2_dir_q);
  assign dir_all    = {p2_dir_eff, p1_dir_eff};
  assign lat_all    = {p2_lat_q, p1_lat_q};

  assign drv_val = single_chip ? lat_all : ext_addr;

// ----------------------------------------------------------------------
// APB access decode
// ----------------------------------------------------------------------
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign sel       = agp_decode(paddr);
  // Only the low byte lane carries register data
  assign wr_en     = access_ph & pwrite & pstrb[0] &
                     (sel != `AGP_SEL_NONE);
  assign dir_wr_ok = wr_en & ~exp_norom;

  // One strobe per register keeps the update process flat
  assign p1_dir_we = dir_wr_ok & (sel == `AGP_SEL_P1_DIR);
  assign p2_dir_we = dir_wr_ok & (sel == `AGP_SEL_P2_DIR);
  assign p1_lat_we = wr_en & (sel == `AGP_SEL_P1_LAT);
  assign p2_lat_we = wr_en & (sel == `AGP_SEL_P2_LAT);
  assign p2_pup_we = wr_en & (sel == `AGP_SEL_P2_PUP);

// ----------------------------------------------------------------------
// Port registers
// ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p1_dir_q <= `AGP_DIR_RST;
      p2_dir_q <= `AGP_DIR_RST;
      p1_lat_q <= `AGP_LAT_RST;
      p2_lat_q <= `AGP_LAT_RST;
      p2_pup_q <= `AGP_PUP_RST;
    end else if (hw_stby) begin
      p1_dir_q <= `AGP_DIR_RST;
      p2_dir_q <= `AGP_DIR_RST;
      p1_lat_q <= `AGP_LAT_RST;
      p2_lat_q <= `AGP_LAT_RST;
      p2_pup_q <= `AGP_PUP_RST;
    end else begin
      if (p1_dir_we) begin
        p1_dir_q <= pwdata[7:0];
      end
      if (p2_dir_we) begin
        p2_dir_q <= pwdata[7:0];
      end
      if (p1_lat_we) begin
        p1_lat_q <= pwdata[7:0];
      end
      if (p2_lat_we) begin
        p2_lat_q <= pwdata[7:0];
      end
      if (p2_pup_we) begin
        p2_pup_q <= pwdata[7:0];
      end
    end
  end

// ----------------------------------------------------------------------
// Read data
// ----------------------------------------------------------------------
  // Pins sampled at setup; two sync stages make them lag the pad
  always @* begin
    prdata_d = 32'h0000_0000;
    case (sel)
      `AGP_SEL_P1_DIR: begin
        prdata_d[7:0] = `AGP_WO_READ;
      end
      `AGP_SEL_P2_DIR: begin
        prdata_d[7:0] = `AGP_WO_READ;
      end
      `AGP_SEL_P1_LAT: begin
        prdata_d[7:0] = agp_readback(p1_dir_eff, p1_lat_q, pin_s[7:0]);
      end
      `AGP_SEL_P2_LAT: begin
        prdata_d[7:0] = agp_readback(p2_dir_eff, p2_lat_q,
                                     pin_s[15:8]);
      end
      `AGP_SEL_P2_PUP: begin
        prdata_d[7:0] = p2_pup_q;
      end
      default: begin
        prdata_d = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup_ph) begin
      prdata_q  <= pwrite ? 32'h0000_0000 : prdata_d;
      pslverr_q <= (sel == `AGP_SEL_NONE);
    end else if (!psel) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
  end

  // Zero wait states: every access phase completes at once
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

// ----------------------------------------------------------------------
// Pin drivers
// ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_pin
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_out_q[gi] <= 1'b0;
          pin_oe_q[gi]  <= 1'b0;
        end else if (hw_stby) begin
          pin_out_q[gi] <= 1'b0;
          pin_oe_q[gi]  <= 1'b0;
        end else if (sw_standby) begin
          pin_out_q[gi] <= pin_out_q[gi];
          pin_oe_q[gi]  <= pin_oe_q[gi];
        end else begin
          pin_out_q[gi] <= drv_val[gi];
          pin_oe_q[gi]  <= dir_all[gi];
        end
      end
    end
  endgenerate

  assign p1_pin_out = pin_out_q[7:0];
  assign p1_pin_oe  = pin_oe_q[7:0];
  assign p2_pin_out = pin_out_q[15:8];
  assign p2_pin_oe  = pin_oe_q[15:8];

// ----------------------------------------------------------------------
// Port 2 pull-ups
// ----------------------------------------------------------------------
  always @* begin
    if (exp_norom || hw_stby) begin
      pup_d = 8'h00;
    end else begin
      pup_d = p2_pup_q & ~p2_dir_q;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pup_q <= 8'h00;
    end else begin
      pup_q <= pup_d;
    end
  end

  assign p2_pullup_on = pup_q;

endmodule // agp_top

// ==== sim/agp_props_properties.sv ====
`timescale 1ns/1ps
`include "agp_map.vh"
module agp_props (
  // Clock and reset
  input wire                   pclk,
  input wire                   presetn,
  // APB
  input wire                   psel,
  input wire                   penable,
  input wire                   pwrite,
  input wire [`AGP_ADDR_W-1:0] paddr,
  input wire [31:0]            prdata,
  // Mode, power, bus
  input wire [2:0]             mode_pins,
  input wire                   hw_standby_n,
  input wire                   sw_standby,
  input wire [15:0]            ext_addr,
  // Pins
  input wire [7:0]             p1_pin_out,
  input wire [7:0]             p1_pin_oe,
  input wire [7:0]             p2_pin_out,
  input wire [7:0]             p2_pin_oe,
  input wire [7:0]             p2_pullup_on
);
  localparam [17:0] A_P1D = {`AGP_P1_DIR_IDX, 2'b00};
  localparam [17:0] A_P2D = {`AGP_P2_DIR_IDX, 2'b00};
  localparam [17:0] A_P1L = {`AGP_P1_LAT_IDX, 2'b00};
  reg  [3:0] run_q;
  reg  [2:0] mode_q;
  wire       run   = run_q > 4'h7;
  wire       exp_m = mode_pins == `AGP_MODE_EXP1 ||
                     mode_pins == `AGP_MODE_EXP3;
  wire       rom_m = mode_pins == `AGP_MODE_EXPROM;
  // Settled: strap latched and standby sync long past
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q  <= 4'h0;
      mode_q <= 3'h0;
    end else begin
      mode_q <= mode_pins;
      if (!hw_standby_n || mode_q != mode_pins) run_q <= 4'h0;
      else if (run_q != 4'hf) run_q <= run_q + 4'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Sequences and properties
  // ----------------------------------------------------------------
  sequence s_quiet; run && !sw_standby && !$past(sw_standby); endsequence
  sequence s_rd(a); psel && penable && !pwrite && paddr == a; endsequence
  sequence s_hw_low; !hw_standby_n [*5]; endsequence
  property p_p1_addr; s_quiet ##0 exp_m |->
    p1_pin_oe == 8'hff && p1_pin_out == $past(ext_addr[7:0]); endproperty
  property p_p2_addr; s_quiet ##0 exp_m |->
    p2_pin_oe == 8'hff && p2_pin_out == $past(ext_addr[15:8]); endproperty
  property p_rom_addr; s_quiet ##0 rom_m |-> p1_pin_out ==
    $past(ext_addr[7:0]) && p2_pin_out == $past(ext_addr[15:8]); endproperty
  property p_pull_exp; run && exp_m |-> p2_pullup_on == 8'h00; endproperty
  property p_pull_dir; s_quiet ##0 !exp_m |->
    (p2_pullup_on & p2_pin_oe) == 8'h00; endproperty
  property p_sw_hold; run && $past(run) && $past(sw_standby) |->
    $stable(p1_pin_out) && $stable(p1_pin_oe) && $stable(p2_pin_out);
  endproperty
  property p_hw_clear; s_hw_low |=> p1_pin_oe == 8'h00 &&
    p2_pin_oe == 8'h00 && p2_pullup_on == 8'h00; endproperty
  property p_dir_read; psel && penable && !pwrite &&
    (paddr == A_P1D || paddr == A_P2D) |-> prdata[7:0] == 8'hff; endproperty
  property p_lat_read; s_quiet ##0 s_rd(A_P1L) ##0 !exp_m && !rom_m |->
    ((prdata[7:0] ^ p1_pin_out) & p1_pin_oe) == 8'h00; endproperty
  a_p1_addr: assert property (p_p1_addr)
    else $error("port1 not on address bus");
  a_p2_addr: assert property (p_p2_addr)
    else $error("port2 not on address bus");
  a_rom_addr: assert property (p_rom_addr)
    else $error("address value wrong in rom mode");
  a_pull_exp: assert property (p_pull_exp)
    else $error("pull-up on in expanded mode");
  a_pull_dir: assert property (p_pull_dir)
    else $error("pull-up on a driven pin");
  a_sw_hold: assert property (p_sw_hold)
    else $error("pins moved in software standby");
  a_hw_clear: assert property (p_hw_clear)
    else $error("pins not off in hardware standby");
  a_dir_read: assert property (p_dir_read)
    else $error("direction read not all ones");
  a_lat_read: assert property (p_lat_read)
    else $error("output pin read differs from latch");
endmodule // agp_props
bind agp_top agp_props i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .mode_pins(mode_pins),
  .hw_standby_n(hw_standby_n), .sw_standby(sw_standby),
  .ext_addr(ext_addr), .p1_pin_out(p1_pin_out), .p1_pin_oe(p1_pin_oe),
  .p2_pin_out(p2_pin_out), .p2_pin_oe(p2_pin_oe),
  .p2_pullup_on(p2_pullup_on));

// ==== sim/agp_pins.sv ====
`timescale 1ns/1ps
module agp_pins (
  // Clock
  input  wire       pclk,
  // Design side
  input  wire [7:0] p1_out,
  input  wire [7:0] p1_oe,
  input  wire [7:0] p2_out,
  input  wire [7:0] p2_oe,
  input  wire [7:0] p2_pull,
  // Outside drivers
  input  wire [7:0] x1_val,
  input  wire [7:0] x1_en,
  input  wire [7:0] x2_val,
  input  wire [7:0] x2_en,
  // Wire levels
  output wire [7:0] p1_lvl,
  output wire [7:0] p2_lvl
);
  reg [7:0] flt_q = 8'h5a;
  // Undriven lines wander so a stale read cannot match
  always @(posedge pclk) flt_q <= ~flt_q;
  assign p1_lvl = (p1_oe & p1_out) | (~p1_oe & x1_en & x1_val) |
                  (~p1_oe & ~x1_en & flt_q);
  // pull-up holds an undriven pin high
  assign p2_lvl = (p2_oe & p2_out) | (~p2_oe & x2_en & x2_val) |
                  (~p2_oe & ~x2_en & (p2_pull | flt_q));
endmodule // agp_pins

// ==== sim/agp_top_test.sv ====
`timescale 1ns/1ps
`include "agp_map.vh"
module agp_top_test;
  localparam [17:0] A_P1D = {`AGP_P1_DIR_IDX, 2'b00};
  localparam [17:0] A_P2D = {`AGP_P2_DIR_IDX, 2'b00};
  localparam [17:0] A_P1L = {`AGP_P1_LAT_IDX, 2'b00};
  localparam [17:0] A_P2L = {`AGP_P2_LAT_IDX, 2'b00};
  localparam [17:0] A_P2P = {`AGP_P2_PUP_IDX, 2'b00};
  reg         pclk, presetn, psel, penable, pwrite, hw_standby_n, sw_standby;
  reg  [17:0] paddr;
  reg  [31:0] pwdata, rdata;
  reg  [3:0]  pstrb;
  reg  [2:0]  mode_pins;
  reg  [15:0] ext_addr;
  reg  [7:0]  x1_val, x1_en, x2_val, x2_en;
  reg         rerr;
  wire [31:0] prdata;
  wire        pready, pslverr;
  wire [7:0]  p1_out, p1_oe, p1_in, p2_out, p2_oe, p2_in, p2_pu;
  int         failures, total_checks, i;
  agp_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_pins(mode_pins), .hw_standby_n(hw_standby_n),
    .sw_standby(sw_standby), .ext_addr(ext_addr), .p1_pin_in(p1_in),
    .p1_pin_out(p1_out), .p1_pin_oe(p1_oe), .p2_pin_in(p2_in),
    .p2_pin_out(p2_out), .p2_pin_oe(p2_oe), .p2_pullup_on(p2_pu));
  agp_pins i_pins (.pclk(pclk), .p1_out(p1_out), .p1_oe(p1_oe),
    .p2_out(p2_out), .p2_oe(p2_oe), .p2_pull(p2_pu), .x1_val(x1_val),
    .x1_en(x1_en), .x2_val(x2_val), .x2_en(x2_en), .p1_lvl(p1_in),
    .p2_lvl(p2_in));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task apb(input [17:0] a, input wr, input [7:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a;
    pwdata <= {24'h0, d}; pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Slave sets the wait; only the watchdog ends a stuck one
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task do_reset(input [2:0] m);
    mode_pins <= m; presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    tick(8);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    #40000;
    failures++;
    tally_and_finish;
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, sw_standby} = 5'h0;
    hw_standby_n = 1'b1; paddr = 18'h0; pwdata = 32'h0; pstrb = 4'h0;
    mode_pins = 3'h7; ext_addr = 16'h5ac3;
    {x1_val, x1_en, x2_val, x2_en} = 32'h0;
    for (i = 6; i < 8; i++) begin
      do_reset(i[2:0]);
      apb(A_P1D, 1'b0, 8'h0); chk("p1 dir read", 32'hff, rdata);
      chk("p1 oe at reset", 8'h00, p1_oe);
      apb(A_P1D, 1'b1, 8'hff); apb(A_P1L, 1'b0, 8'h0);
      chk("p1 latch at reset", 32'h0, rdata);
      apb(A_P1L, 1'b1, 8'ha5); tick(2);
      chk("p1 out", 8'ha5, p1_out); chk("p1 oe", 8'hff, p1_oe);
      apb(A_P1L, 1'b0, 8'h0); chk("p1 latch", 32'ha5, rdata);
    end
    x1_en <= 8'hf0; x1_val <= 8'h3c; x2_en <= 8'h30; x2_val <= 8'h20;
    apb(A_P1D, 1'b1, 8'h0f); apb(A_P1L, 1'b1, 8'h96);
    apb(A_P2D, 1'b1, 8'h0f); apb(A_P2L, 1'b1, 8'h5a);
    apb(A_P2P, 1'b1, 8'hff); tick(4);
    apb(A_P1L, 1'b0, 8'h0); chk("p1 mixed read", 32'h36, rdata);
    chk("p2 pull-ups", 8'hf0, p2_pu);
    chk("p2 oe", 8'h0f, p2_oe);
    chk("p2 out", 8'h0a, p2_out & p2_oe);
    apb(A_P2L, 1'b0, 8'h0); chk("p2 mixed read", 32'hea, rdata);
    apb(A_P2P, 1'b0, 8'h0); chk("p2 pull ctl", 32'hff, rdata);
    sw_standby <= 1'b1;
    apb(A_P1L, 1'b1, 8'h69); tick(3);
    chk("p1 out frozen", 8'h96, p1_out);
    apb(A_P1L, 1'b0, 8'h0); chk("p1 latch standby", 32'h39, rdata);
    sw_standby <= 1'b0; tick(3);
    chk("p1 out after standby", 8'h69, p1_out);
    apb(18'h3fff0, 1'b0, 8'h0); chk("unmapped error", 32'h1, {31'h0, rerr});
    apb(A_P1L + 18'h2, 1'b1, 8'hff);
    chk("misaligned error", 32'h1, {31'h0, rerr});
    apb(A_P1L, 1'b0, 8'h0); chk("latch kept", 32'h39, rdata);
    hw_standby_n <= 1'b0; tick(6);
    chk("p2 pull hw standby", 8'h00, p2_pu);
    @(posedge pclk);
    hw_standby_n <= 1'b1; tick(4);
    chk("p1 oe after hw", 8'h00, p1_oe);
    apb(A_P2P, 1'b0, 8'h0); chk("pull ctl after hw", 32'h0, rdata);
    apb(A_P1D, 1'b1, 8'hff); apb(A_P1L, 1'b0, 8'h0);
    chk("p1 latch after hw", 32'h0, rdata);
    x1_en <= 8'hff;
    do_reset(3'h5);
    chk("p1 oe rom reset", 8'h00, p1_oe);
    apb(A_P1D, 1'b1, 8'hf0); apb(A_P2D, 1'b1, 8'h0f); tick(4);
    chk("p1 oe rom", 8'hf0, p1_oe);
    chk("p2 oe rom", 8'h0f, p2_oe);
    chk("p1 addr rom", ext_addr[7:0], p1_out);
    apb(A_P1L, 1'b0, 8'h0); chk("p1 rom read", 32'h0c, rdata);
    for (i = 1; i < 4; i += 2) begin
      ext_addr <= 16'h5ac3 ^ {16{i[1]}};
      do_reset(i[2:0]);
      chk("p1 oe exp", 8'hff, p1_oe);
      chk("p1 addr exp", ext_addr[7:0], p1_out);
      chk("p2 addr exp", {8'hff, ext_addr[15:8]}, {p2_oe, p2_out});
      apb(A_P1D, 1'b1, 8'h00); apb(A_P2P, 1'b1, 8'hff);
      apb(A_P1L, 1'b1, 8'ha5); tick(3);
      chk("p1 oe kept", 8'hff, p1_oe);
      chk("p2 pull exp", 8'h00, p2_pu);
      apb(A_P1L, 1'b0, 8'h0); chk("p1 latch exp", 32'ha5, rdata);
    end
    tally_and_finish;
  end
endmodule // agp_top_test
